// file: design/sssc_defs.vh
// register map, field positions and reset values of the supply switch control
`ifndef SSSC_DEFS_VH
`define SSSC_DEFS_VH

// register indices; byte address is four times the index
`define SSSC_IDX_RNG_DATA    20'h06105
`define SSSC_IDX_SWITCH_CTRL 20'h06106
`define SSSC_IDX_IRQ_STATUS  20'h06107
`define SSSC_IDX_IRQ_MASK    20'h06108

// apb address width and register data width
`define SSSC_AW 20
`define SSSC_DW 8

// fields of switch_and_random_control
`define SSSC_BIT_RSVD_LO   0
`define SSSC_BIT_RND_RDY   1
`define SSSC_BIT_FORCE_RNG 2
`define SSSC_BIT_LIM_OFF   3
`define SSSC_BIT_SW_EN     4
`define SSSC_BIT_OVERLOAD  5
`define SSSC_BIT_HIDE_SIG  6
`define SSSC_BIT_RSVD_HI   7

// reset values of the writable control bits
`define SSSC_RST_RND_RDY   1'b0
`define SSSC_RST_FORCE_RNG 1'b0
`define SSSC_RST_LIM_OFF   1'b0
`define SSSC_RST_SW_EN     1'b0
`define SSSC_RST_HIDE_SIG  1'b1
// fixed values of the reserved bits
`define SSSC_FIX_RSVD_HI   1'b0
`define SSSC_FIX_RSVD_LO   1'b1

// interrupt status and mask fields
`define SSSC_IRQ_RND_RDY   0
`define SSSC_IRQ_OVERLOAD  1
`define SSSC_IRQ_W         2
`define SSSC_RST_IRQ_MASK  2'h0

`endif

// file: design/sssc_ctrl.v
// secure supply switch, input masking and random generator control register
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
// How it works
// RL1: all control bits share one register
// RL2: inrush limit active unless disable bit set
// RL3: switch enable bit gates companion supply
// RL4: overcurrent bit mirrors limiter, read only
// RL5: mask bit forces secure input 0, port 1
// RL6: firmware masks inputs around switch toggles
// RL7: force bit keeps random generator running
// RL8: ready sets on new value, read clears
// RL9: reset: mask 1, bit0 1, others 0
// RL10: reserved and overcurrent writes ignored
`include "sssc_defs.vh"

module sssc_ctrl
(
  // clock and reset
  input  wire                 clk_sys_i,
  input  wire                 rst_n_i,
  // apb slave
  input  wire                 psel_i,
  input  wire                 penable_i,
  input  wire                 pwrite_i,
  input  wire [`SSSC_AW-1:0]  paddr_i,
  input  wire [31:0]          pwdata_i,
  input  wire [3:0]           pstrb_i,
  output reg                  pready_o,
  output reg  [31:0]          prdata_o,
  output reg                  pslverr_o,
  // pads and analog limiter, asynchronous
  input  wire                 secure_signal_input_pad_i,
  input  wire                 port3_bit4_pad_i,
  input  wire                 overload_i,
  // random generator, same clock
  input  wire                 rng_valid_i,
  input  wire [`SSSC_DW-1:0]  rng_value_i,
  input  wire                 contactless_unit_rng_req_i,
  // switch and masking controls
  output reg                  svdd_switch_en_o,
  output reg                  inrush_limit_en_o,
  output reg                  rng_run_o,
  output reg                  secure_signal_input_o,
  output reg                  port3_bit4_o,
  // interrupt
  output reg                  irq_o
);

  // reset release synchroniser
  reg        rst_meta_q;
  reg        rst_sync_q;
  wire       rst_n;

  // pad and limiter synchronisers
  reg  [2:0] in_meta_q;
  reg  [2:0] in_sync_q;
  reg        ovl_prev_q;

  // register contents
  reg                 rnd_rdy_q;
  reg                 force_rng_q;
  reg                 lim_off_q;
  reg                 sw_en_q;
  reg                 hide_sig_q;
  reg [`SSSC_DW-1:0]  rng_data_q;
  reg [`SSSC_IRQ_W-1:0] irq_stat_q;
  reg [`SSSC_IRQ_W-1:0] irq_mask_q;

  // bus decode
  wire                 setup_ph;
  wire                 access_ph;
  wire [`SSSC_AW-1:0]  idx;
  wire                 addr_ok;
  wire                 low_aligned;
  wire                 wr_ok;
  wire                 wr_ctrl;
  wire                 wr_stat;
  wire                 wr_mask;
  wire                 rd_rng;
  wire [`SSSC_DW-1:0]  ctrl_view;
  reg  [31:0]          rd_mux;
  wire                 ovl_sync;
  wire                 rnd_evt;
  wire                 ovl_evt;
  wire [`SSSC_IRQ_W-1:0] irq_evt;

  // next values of the registers and of the registered outputs
  reg                 force_rng_d;
  reg                 lim_off_d;
  reg                 sw_en_d;
  reg                 hide_sig_d;
  reg                 rnd_rdy_d;
  reg [`SSSC_DW-1:0]  rng_data_d;
  reg [`SSSC_IRQ_W-1:0] irq_mask_d;
  reg                 pready_d;
  reg                 pslverr_d;
  reg [31:0]          prdata_d;
  reg                 svdd_switch_en_d;
  reg                 inrush_limit_en_d;
  reg                 rng_run_d;
  reg                 secure_signal_input_d;
  reg                 port3_bit4_d;
  reg                 irq_d;

  // reset asserts at once and releases after two edges
  always @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_n = rst_sync_q;

  // two flops for each asynchronous input; bit0 secure in, 1 port, 2 limiter
  always @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_meta_q <= 3'h0;
      in_sync_q <= 3'h0;
    end
    else
    begin
      in_meta_q <= {overload_i, port3_bit4_pad_i, secure_signal_input_pad_i};
      in_sync_q <= in_meta_q;
    end
  end

  assign ovl_sync = in_sync_q[2];

  // apb phases; the slave answers in the first access cycle
  assign setup_ph  = psel_i & ~penable_i;
  assign access_ph = psel_i & penable_i & pready_o;
  assign idx       = {2'h0, paddr_i[`SSSC_AW-1:2]};
  assign low_aligned = (paddr_i[1:0] == 2'h0);
  assign addr_ok   = low_aligned &
                     ((idx == `SSSC_IDX_RNG_DATA)    |
                      (idx == `SSSC_IDX_SWITCH_CTRL) |
                      (idx == `SSSC_IDX_IRQ_STATUS)  |
                      (idx == `SSSC_IDX_IRQ_MASK));

  // writes land only through byte lane 0, where the 8-bit data sits
  assign wr_ok   = access_ph & pwrite_i & addr_ok & pstrb_i[0];
  assign wr_ctrl = wr_ok & (idx == `SSSC_IDX_SWITCH_CTRL); // RL1
  assign wr_stat = wr_ok & (idx == `SSSC_IDX_IRQ_STATUS);
  assign wr_mask = wr_ok & (idx == `SSSC_IDX_IRQ_MASK);
  assign rd_rng  = access_ph & ~pwrite_i & low_aligned &
                   (idx == `SSSC_IDX_RNG_DATA);

  // control register view with the fixed and live bits
  assign ctrl_view = {`SSSC_FIX_RSVD_HI, // RL9
                      hide_sig_q,
                      ovl_sync,          // RL4
                      sw_en_q,
                      lim_off_q,
                      force_rng_q,
                      rnd_rdy_q,
                      `SSSC_FIX_RSVD_LO}; // RL9

  // read data selection by register index
  always @*
  begin
    rd_mux = 32'h0;
    case (idx)
      `SSSC_IDX_RNG_DATA:    rd_mux = {24'h0, rng_data_q};
      `SSSC_IDX_SWITCH_CTRL: rd_mux = {24'h0, ctrl_view}; // RL1
      `SSSC_IDX_IRQ_STATUS:  rd_mux = {30'h0, irq_stat_q};
      `SSSC_IDX_IRQ_MASK:    rd_mux = {30'h0, irq_mask_q};
      default:               rd_mux = 32'h0;
    endcase
  end

  // answer prepared in setup, presented for one access cycle
  always @*
  begin
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    prdata_d  = 32'h0;
    if (setup_ph)
    begin
      pready_d  = 1'b1;
      pslverr_d = ~addr_ok;
      prdata_d  = (addr_ok & ~pwrite_i) ? rd_mux : 32'h0;
    end
  end

  // bus answer flops; all zero outside the access cycle
  always @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o  <= pready_d;
      prdata_o  <= prdata_d;
      pslverr_o <= pslverr_d;
    end
  end

  // control bits load from the write data on an accepted write
  always @*
  begin
    force_rng_d = force_rng_q;
    lim_off_d   = lim_off_q;
    sw_en_d     = sw_en_q;
    hide_sig_d  = hide_sig_q;
    if (wr_ctrl)
    begin
      // bits 7, 5 and 0 of the write data are dropped
      force_rng_d = pwdata_i[`SSSC_BIT_FORCE_RNG]; // RL10
      lim_off_d   = pwdata_i[`SSSC_BIT_LIM_OFF];
      sw_en_d     = pwdata_i[`SSSC_BIT_SW_EN];
      hide_sig_d  = pwdata_i[`SSSC_BIT_HIDE_SIG];
    end
  end

  // writable control bits; reserved and limiter bits are not stored
  always @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      force_rng_q <= `SSSC_RST_FORCE_RNG; // RL9
      lim_off_q   <= `SSSC_RST_LIM_OFF;
      sw_en_q     <= `SSSC_RST_SW_EN;
      hide_sig_q  <= `SSSC_RST_HIDE_SIG;  // RL9
    end
    else
    begin
      force_rng_q <= force_rng_d;
      lim_off_q   <= lim_off_d;
      sw_en_q     <= sw_en_d;
      hide_sig_q  <= hide_sig_d;
    end
  end

  // random value capture and ready flag; a new value beats a clear
  always @*
  begin
    rng_data_d = rng_data_q;
    rnd_rdy_d  = rnd_rdy_q;
    if (rng_valid_i)
    begin
      rng_data_d = rng_value_i;
      rnd_rdy_d  = 1'b1;                            // RL8
    end
    else if (rd_rng)
      rnd_rdy_d  = 1'b0;                            // RL8
    else if (wr_ctrl)
      rnd_rdy_d  = pwdata_i[`SSSC_BIT_RND_RDY];
  end

  // random value and ready flag flops
  always @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rnd_rdy_q  <= `SSSC_RST_RND_RDY;
      rng_data_q <= {`SSSC_DW{1'b0}};
    end
    else
    begin
      rng_data_q <= rng_data_d;
      rnd_rdy_q  <= rnd_rdy_d;
    end
  end

  // rising edge of the synchronised limiter; the random event is rng_valid_i itself
  always @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      ovl_prev_q <= 1'b0;
    else
      ovl_prev_q <= ovl_sync;
  end

  assign rnd_evt = rng_valid_i;
  assign ovl_evt = ovl_sync & ~ovl_prev_q;
  assign irq_evt = {ovl_evt, rnd_evt};

  // sticky status per event; an event beats a write-one clear
  genvar g;
  generate
    for (g = 0; g < `SSSC_IRQ_W; g = g + 1)
    begin : g_irq
      always @(posedge clk_sys_i or negedge rst_n)
      begin
        if (!rst_n)
          irq_stat_q[g] <= 1'b0;
        else if (irq_evt[g])
          irq_stat_q[g] <= 1'b1;
        else if (wr_stat & pwdata_i[g])
          irq_stat_q[g] <= 1'b0;
      end
    end
  endgenerate

  // interrupt mask loads from the low write bits
  always @*
  begin
    irq_mask_d = irq_mask_q;
    if (wr_mask)
      irq_mask_d = pwdata_i[`SSSC_IRQ_W-1:0];
  end

  // interrupt mask register
  always @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      irq_mask_q <= `SSSC_RST_IRQ_MASK;
    else
      irq_mask_q <= irq_mask_d;
  end

  // registered outputs to the switches, generator, inputs and interrupt
  always @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      svdd_switch_en_o      <= 1'b0;
      inrush_limit_en_o     <= 1'b1;
      rng_run_o             <= 1'b0;
      secure_signal_input_o <= 1'b0;
      port3_bit4_o          <= 1'b1;
      irq_o                 <= 1'b0;
    end
    else
    begin
      svdd_switch_en_o      <= svdd_switch_en_d;
      inrush_limit_en_o     <= inrush_limit_en_d;
      rng_run_o             <= rng_run_d;
      secure_signal_input_o <= secure_signal_input_d;
      port3_bit4_o          <= port3_bit4_d;
      irq_o                 <= irq_d;
    end
  end

  // next values of the switch, generator, input and interrupt outputs
  always @*
  begin
    // companion supply off means output held at ground
    svdd_switch_en_d      = sw_en_q;                          // RL3
    inrush_limit_en_d     = ~lim_off_q;                       // RL2
    rng_run_d = force_rng_q | contactless_unit_rng_req_i;     // RL7
    // masking hides spikes while firmware toggles the switch
    secure_signal_input_d = hide_sig_q ? 1'b0 : in_sync_q[0]; // RL5 RL6
    port3_bit4_d          = hide_sig_q ? 1'b1 : in_sync_q[1]; // RL5
    irq_d                 = |(irq_stat_q & irq_mask_q);
  end

endmodule // sssc_ctrl

// file: dv/sssc_ctrl_asserts.sv
// port assertions for the supply switch control block
`timescale 1ns/10ps
`include "sssc_defs.vh"

module sssc_chk
(
  // clock, reset and apb
  input wire                clk_sys_i,
  input wire                rst_n_i,
  input wire                psel_i,
  input wire                penable_i,
  input wire                pwrite_i,
  input wire [`SSSC_AW-1:0] paddr_i,
  input wire [31:0]         pwdata_i,
  input wire [3:0]          pstrb_i,
  input wire                pready_o,
  input wire [31:0]         prdata_o,
  input wire                pslverr_o,
  // pads, generator request and controls
  input wire                secure_signal_input_pad_i,
  input wire                port3_bit4_pad_i,
  input wire                contactless_unit_rng_req_i,
  input wire                svdd_switch_en_o,
  input wire                inrush_limit_en_o,
  input wire                rng_run_o,
  input wire                secure_signal_input_o,
  input wire                port3_bit4_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  // setup cycle and control write seen on the bus
  wire setup_w = psel_i && !penable_i;
  wire ctl_wr  = setup_w && pwrite_i && pstrb_i[0]
                 && paddr_i == (`SSSC_IDX_SWITCH_CTRL << 2);

  a_ready_after_setup: assert property (setup_w |=> pready_o)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  a_data_idle_zero: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data outside answer");
  a_upper_zero: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_err_misalign: assert property (setup_w && paddr_i[1:0] != 2'h0
    |=> pslverr_o && prdata_o == 32'h0) else $error("bad address taken");
  a_port_follow: assert property (!port3_bit4_o
    |-> !$past(port3_bit4_pad_i, 3)) else $error("port low without pad");
  a_sig_follow: assert property (secure_signal_input_o
    |-> $past(secure_signal_input_pad_i, 3)) else $error("input without pad");
  a_run_on_req: assert property (contactless_unit_rng_req_i[*2]
    |-> rng_run_o) else $error("generator idle on request");
  a_switch_write: assert property (ctl_wr |-> ##3
    svdd_switch_en_o == $past(pwdata_i[4], 3)
    && inrush_limit_en_o == !$past(pwdata_i[3], 3))
    else $error("switch outputs miss control write");
endmodule // sssc_chk

bind sssc_ctrl sssc_chk u_sssc_chk (.*);

// file: dv/secure_supply_switch_ctrl_test.sv
// self-checking bench for the supply switch control block
`timescale 1ns/10ps
`include "sssc_defs.vh"

module secure_supply_switch_ctrl_test;
  localparam logic [19:0] A_RNG = `SSSC_IDX_RNG_DATA << 2;
  localparam logic [19:0] A_CTL = `SSSC_IDX_SWITCH_CTRL << 2;
  localparam logic [19:0] A_STA = `SSSC_IDX_IRQ_STATUS << 2;
  localparam logic [19:0] A_MSK = `SSSC_IDX_IRQ_MASK << 2;
  // stimulus, observed ports and counters
  logic        clk_sys_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0;
  logic        pwrite_i = 0, overload_i = 0, rng_valid_i = 0;
  logic        secure_signal_input_pad_i = 1, port3_bit4_pad_i = 0;
  logic        contactless_unit_rng_req_i = 0;
  logic [19:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o, rd_q;
  logic [7:0]  rng_value_i = 0;
  logic [3:0]  pstrb_i = 0;
  logic        pready_o, pslverr_o, svdd_switch_en_o, inrush_limit_en_o;
  logic        rng_run_o, secure_signal_input_o, port3_bit4_o, irq_o, er_q;
  int          mismatches = 0, cmp_count = 0;
  // rows: written value, read back, {svdd,inrush,run,input,port}
  logic [20:0] rows [4] = '{{8'hff, 8'h5f, 5'h15}, {8'h00, 8'h01, 5'h0a},
                            {8'h54, 8'h55, 5'h1d}, {8'h28, 8'h09, 5'h02}};
  wire  [31:0] outs = {27'h0, svdd_switch_en_o, inrush_limit_en_o, rng_run_o,
                       secure_signal_input_o, port3_bit4_o};

  sssc_ctrl u_sssc_ctrl (.*);

  // 50 mhz clock
  always #10 clk_sys_i = ~clk_sys_i;

  task chk(input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, x);
    end
  endtask

  // one apb transfer, held until ready is sampled
  task apb(input logic w, input logic [19:0] a, input logic [31:0] d,
           input logic [3:0] s);
    @(posedge clk_sys_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    pstrb_i <= s;
    @(posedge clk_sys_i);
    penable_i <= 1;
    // only the watchdog ends a wait that never sees ready
    do
    begin
      @(posedge clk_sys_i);
    end
    while (pready_o !== 1'b1);
    rd_q = prdata_o;
    er_q = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask

  task wr(input logic [19:0] a, input logic [31:0] d);
    apb(1, a, d, 4'hf);
  endtask

  task rd(input logic [19:0] a);
    apb(0, a, 32'h0, 4'h0);
  endtask

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog
  initial
  begin
    #100000;
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop;
  end

  initial
  begin
    repeat (8) @(posedge clk_sys_i);
    rst_n_i <= 1;
    repeat (3) @(posedge clk_sys_i);
    rd(A_CTL);
    chk(rd_q, 32'h41);
    chk(outs, 32'h09);
    $display("reset values done");
    foreach (rows[i])
    begin
      wr(A_CTL, {24'h0, rows[i][20:13]});
      repeat (4) @(posedge clk_sys_i);
      rd(A_CTL);
      chk(rd_q, {24'h0, rows[i][12:5]});
      chk(outs, {27'h0, rows[i][4:0]});
    end
    $display("control table done");
    // write without lane 0 is dropped
    apb(1, A_CTL, 32'hff, 4'h0);
    rd(A_CTL);
    chk(rd_q, 32'h09);
    // overload shows live, status sticky, interrupt masked then cleared
    overload_i <= 1;
    repeat (4) @(posedge clk_sys_i);
    rd(A_CTL);
    chk(rd_q, 32'h29);
    rd(A_STA);
    chk(rd_q, 32'h2);
    chk(irq_o, 32'h0);
    wr(A_MSK, 32'h3);
    repeat (2) @(posedge clk_sys_i);
    chk(irq_o, 32'h1);
    wr(A_STA, 32'h2);
    overload_i <= 0;
    repeat (2) @(posedge clk_sys_i);
    chk(irq_o, 32'h0);
    $display("overload done");
    // new random value, ready cleared by reading it
    rng_value_i <= 8'ha5;
    rng_valid_i <= 1;
    @(posedge clk_sys_i);
    rng_valid_i <= 0;
    repeat (2) @(posedge clk_sys_i);
    chk(irq_o, 32'h1);
    rd(A_CTL);
    chk(rd_q, 32'h0b);
    rd(A_RNG);
    chk(rd_q, 32'ha5);
    rd(A_CTL);
    chk(rd_q, 32'h09);
    $display("random done");
    // firmware hides the inputs while it switches the companion supply
    wr(A_CTL, 32'h40);
    wr(A_CTL, 32'h50);
    secure_signal_input_pad_i <= 0;
    port3_bit4_pad_i <= 1;
    @(posedge clk_sys_i);
    secure_signal_input_pad_i <= 1;
    port3_bit4_pad_i <= 0;
    repeat (4) @(posedge clk_sys_i);
    chk(outs, 32'h19);
    wr(A_CTL, 32'h10);
    repeat (4) @(posedge clk_sys_i);
    chk(outs, 32'h1a);
    $display("masked switching done");
    // unmapped and misaligned addresses are refused
    rd(A_MSK + 20'h4);
    chk(er_q, 32'h1);
    rd(A_CTL + 20'h1);
    chk(er_q, 32'h1);
    chk(rd_q, 32'h0);
    $display("address refusal done");
    // generator follows the contactless unit when not forced
    contactless_unit_rng_req_i <= 1;
    repeat (2) @(posedge clk_sys_i);
    chk(rng_run_o, 32'h1);
    contactless_unit_rng_req_i <= 0;
    repeat (2) @(posedge clk_sys_i);
    chk(rng_run_o, 32'h0);
    $display("generator request done");
    // reset in mid-run
    rst_n_i <= 0;
    repeat (2) @(posedge clk_sys_i);
    chk(outs, 32'h09);
    rst_n_i <= 1;
    repeat (3) @(posedge clk_sys_i);
    rd(A_CTL);
    chk(rd_q, 32'h41);
    $display("second reset done");
    report_and_stop;
  end
endmodule // secure_supply_switch_ctrl_test
